// ==== rtl/mcr_bank.sv ====
// Miscellaneous configuration register bank with pin drivers.
// Assumes host strobes on sys_clk; pins and PHY management input are asynchronous.
// Functional notes
// RQ1: Misc bit 2 enables the timer.
// RQ2: Misc bit 1 selects burst address bit.
// RQ3: Ring bit clear: DMA writes unrestricted.
// RQ4: Ring bit set: wrap 40h to start-1.
// RQ5: Timer value two bytes, reset FFh.
// RQ6: Sixteen-bit data port at 10h.
// RQ7: Gap segment one, seven bits, 0Ch.
// RQ8: Gap segment two, seven bits, 12h.
// RQ9: Management bit 7 drives EEPROM clock.
// RQ10: Management bit 6 reads EEPROM data pin.
// RQ11: Management bit 5 drives EEPROM data.
// RQ12: Management bit 4 drives EEPROM select.
// RQ13: Bit 3 to PHY, bit 2 from PHY.
// RQ14: Management bit 0 drives PHY clock.
// RQ15: Bit 1 releases MDIO and EEPROM data.
// RQ16: Buffer bit 6 enables wake interrupts.
// RQ17: Bit 5 clear: interrupt open-drain, low.
// RQ18: Bit 4 sets interrupt active level.
// RQ19: Bit 2 selects static or 60ms pulse.
// RQ20: Bit 1 clear: wake open-drain, low.
// RQ21: Bit 0 sets push-pull wake level.
// RQ22: Host bit-bangs serial transfers by writes.
//
// The strobed register port was decided locally.
`timescale 1ns/1ps
`default_nettype none
module mcr_bank #(
    parameter int WAKE_CYC = mcr_pkg::WAKE_PULSE_CYC
) (
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire mcr_pkg::mcr_req_t req,
    output logic [15:0] rdata,
    input wire logic irq_event,
    input wire logic wake_event,
    input wire logic [7:0] dma_wr_page,
    input wire logic dma_wr_step,
    input wire logic [7:0] receive_ring_start_page,
    input wire logic [1:0] host_addr,
    output logic [7:0] dma_next_page,
    output logic burst_addr_bit,
    output logic gp_timer_enable,
    output logic [15:0] gp_timer_reload,
    output logic [15:0] data_port_out,
    output logic data_port_wr,
    output logic [6:0] frame_gap_segment_one,
    output logic [6:0] frame_gap_segment_two,
    output logic eeprom_clock,
    output logic eeprom_select,
    output logic eeprom_data_o,
    output logic eeprom_data_oe,
    input wire logic eeprom_data_i,
    output logic phy_mdc,
    output logic phy_mdio_o,
    output logic phy_mdio_oe,
    input wire logic phy_mdio_i,
    output logic irq_o,
    output logic irq_oe,
    output logic wake_o,
    output logic wake_oe,
    output logic wake_irq
);
    // ==========================================================
    // Register storage
    logic [7:0] misc_q;
    logic [15:0] gpt_q;
    logic [15:0] data_q;
    logic [6:0] gap1_q;
    logic [6:0] gap2_q;
    logic [7:0] mgmt_q;
    logic [7:0] btype_q;
    logic ee_s1_q, ee_s2_q, md_s1_q, md_s2_q;
    logic wr_data_q;

    function automatic logic hit(input mcr_pkg::mcr_req_t r, input logic [4:0] off);
        hit = r.wr && (r.addr == off);
    endfunction : hit

    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            misc_q <= mcr_pkg::RST_MISC;
        end else if (hit(req, mcr_pkg::OFF_MISC)) begin
            misc_q <= {5'h00, req.wdata[2:0]}; // see RQ1
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            gpt_q <= {mcr_pkg::RST_GPT, mcr_pkg::RST_GPT}; // see RQ5
        end else begin
            if (hit(req, mcr_pkg::OFF_GPT_LO)) begin
                gpt_q[7:0] <= req.wdata[7:0]; // see RQ5
            end
            if (hit(req, mcr_pkg::OFF_GPT_HI)) begin
                gpt_q[15:8] <= req.wdata[7:0]; // see RQ5
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            data_q <= mcr_pkg::RST_DATA;
            wr_data_q <= 1'b0;
        end else begin
            wr_data_q <= hit(req, mcr_pkg::OFF_DATA);
            if (hit(req, mcr_pkg::OFF_DATA)) begin
                data_q <= req.wdata; // see RQ6
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            gap1_q <= mcr_pkg::RST_GAP1;
            gap2_q <= mcr_pkg::RST_GAP2;
        end else begin
            if (hit(req, mcr_pkg::OFF_GAP1)) begin
                gap1_q <= req.wdata[6:0]; // see RQ7
            end
            if (hit(req, mcr_pkg::OFF_GAP2)) begin
                gap2_q <= req.wdata[6:0]; // see RQ8
            end
        end
    end

    // Read-only bits 6 and 2 are never stored.
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            mgmt_q <= mcr_pkg::RST_MGMT;
        end else if (hit(req, mcr_pkg::OFF_MGMT)) begin
            mgmt_q <= req.wdata[7:0] & 8'hbb; // see RQ22
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            btype_q <= mcr_pkg::RST_BTYPE;
        end else if (hit(req, mcr_pkg::OFF_BTYPE)) begin
            btype_q <= req.wdata[7:0] & mcr_pkg::BT_WMASK;
        end
    end

    // ==========================================================
    // Pin synchronisers
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            ee_s1_q <= 1'b0;
            ee_s2_q <= 1'b0;
            md_s1_q <= 1'b0;
            md_s2_q <= 1'b0;
        end else begin
            ee_s1_q <= eeprom_data_i;
            ee_s2_q <= ee_s1_q;
            md_s1_q <= phy_mdio_i;
            md_s2_q <= md_s1_q;
        end
    end

    // ==========================================================
    // Read path
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            rdata <= 16'h0000;
        end else if (req.rd) begin
            case (req.addr)
                mcr_pkg::OFF_MISC: rdata <= {8'h00, misc_q};
                mcr_pkg::OFF_GPT_LO: rdata <= {8'h00, gpt_q[7:0]};
                mcr_pkg::OFF_GPT_HI: rdata <= {8'h00, gpt_q[15:8]};
                mcr_pkg::OFF_DATA: rdata <= data_q;
                mcr_pkg::OFF_GAP1: rdata <= {9'h000, gap1_q};
                mcr_pkg::OFF_GAP2: rdata <= {9'h000, gap2_q};
                mcr_pkg::OFF_MGMT: rdata <= {8'h00, mgmt_q[7], ee_s2_q, mgmt_q[5:3], md_s2_q,
                    mgmt_q[1:0]}; // see RQ10
                mcr_pkg::OFF_BTYPE: rdata <= {8'h00, btype_q};
                default: rdata <= 16'h0000;
            endcase
        end else begin
            rdata <= 16'h0000;
        end
    end

    // ==========================================================
    // Control outputs
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            gp_timer_enable <= 1'b0;
            burst_addr_bit <= 1'b0;
            gp_timer_reload <= 16'hffff;
            data_port_out <= 16'h0000;
            data_port_wr <= 1'b0;
            frame_gap_segment_one <= mcr_pkg::RST_GAP1;
            frame_gap_segment_two <= mcr_pkg::RST_GAP2;
            dma_next_page <= 8'h00;
        end else begin
            gp_timer_enable <= misc_q[mcr_pkg::MISC_TIMER_EN]; // see RQ1
            burst_addr_bit <= misc_q[mcr_pkg::MISC_BURST_SEL] ? host_addr[1] : host_addr[0]; // see RQ2
            gp_timer_reload <= gpt_q;
            data_port_out <= data_q;
            data_port_wr <= wr_data_q;
            frame_gap_segment_one <= gap1_q;
            frame_gap_segment_two <= gap2_q;
            if (!misc_q[mcr_pkg::MISC_TX_RING]) begin
                dma_next_page <= dma_wr_page + {7'h00, dma_wr_step}; // see RQ3
            end else if (dma_wr_step
                && (dma_wr_page + 8'h01 >= receive_ring_start_page)) begin
                dma_next_page <= mcr_pkg::TX_RING_FIRST_PAGE; // see RQ4
            end else begin
                dma_next_page <= dma_wr_page + {7'h00, dma_wr_step}; // see RQ4
            end
        end
    end

    // ==========================================================
    // Serial management pins
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            eeprom_clock <= 1'b0;
            eeprom_select <= 1'b0;
            eeprom_data_o <= 1'b0;
            eeprom_data_oe <= 1'b1;
            phy_mdc <= 1'b0;
            phy_mdio_o <= 1'b0;
            phy_mdio_oe <= 1'b1;
        end else begin
            eeprom_clock <= mgmt_q[mcr_pkg::MG_EE_CLK]; // see RQ9
            eeprom_data_o <= mgmt_q[mcr_pkg::MG_EE_WRITE]; // see RQ11
            eeprom_select <= mgmt_q[mcr_pkg::MG_EE_SEL]; // see RQ12
            phy_mdio_o <= mgmt_q[mcr_pkg::MG_PHY_OUT]; // see RQ13
            phy_mdc <= mgmt_q[mcr_pkg::MG_MDC]; // see RQ14
            eeprom_data_oe <= !mgmt_q[mcr_pkg::MG_DIR]; // see RQ15
            phy_mdio_oe <= !mgmt_q[mcr_pkg::MG_DIR]; // see RQ15
        end
    end

    // ==========================================================
    // Interrupt pin
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            irq_o <= 1'b0;
            irq_oe <= 1'b0;
        end else if (!btype_q[mcr_pkg::BT_IRQ_PUSH]) begin
            irq_o <= 1'b0; // see RQ17
            irq_oe <= irq_event; // see RQ17
        end else begin
            irq_o <= irq_event ^ !btype_q[mcr_pkg::BT_IRQ_HIGH]; // see RQ18
            irq_oe <= 1'b1;
        end
    end

    // ==========================================================
    // Wake indication
    typedef enum logic [2:0] {
        W_IDLE = 3'b001,
        W_PULSE = 3'b010,
        W_STATIC = 3'b100
    } mcr_wake_t;
    mcr_wake_t wst_q;
    logic [23:0] wcnt_q;
    logic wake_act;
    logic wake_prev_q;
    logic wake_rise;

    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            wst_q <= W_IDLE;
            wcnt_q <= 24'h00_0000;
            wake_prev_q <= 1'b0;
        end else begin
            wake_prev_q <= wake_event;
            case (wst_q)
                W_IDLE: begin
                    if (btype_q[mcr_pkg::BT_WAKE_PULSE]) begin
                        if (wake_rise) begin
                            wst_q <= W_PULSE; // see RQ19
                            wcnt_q <= 24'(WAKE_CYC - 1);
                        end
                    end else if (wake_event) begin
                        wst_q <= W_STATIC; // see RQ19
                    end
                end
                W_PULSE: begin
                    if (wcnt_q == 24'h00_0000) begin
                        wst_q <= W_IDLE;
                    end else begin
                        wcnt_q <= wcnt_q - 24'h00_0001;
                    end
                end
                W_STATIC: begin
                    if (!wake_event) begin
                        wst_q <= W_IDLE;
                    end
                end
                default: wst_q <= W_IDLE;
            endcase
        end
    end

    assign wake_act = (wst_q != W_IDLE);
    // A held wake level starts only one pulse.
    assign wake_rise = wake_event && !wake_prev_q;

    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            wake_o <= 1'b0;
            wake_oe <= 1'b0;
            wake_irq <= 1'b0;
        end else begin
            wake_irq <= wake_act && btype_q[mcr_pkg::BT_WAKE_IRQ_EN]; // see RQ16
            if (!btype_q[mcr_pkg::BT_WAKE_PUSH]) begin
                wake_o <= 1'b0; // see RQ20
                wake_oe <= wake_act; // see RQ20
            end else begin
                wake_o <= wake_act ^ !btype_q[mcr_pkg::BT_WAKE_HIGH]; // see RQ21
                wake_oe <= 1'b1;
            end
        end
    end

    // ==========================================================
    // Checks
    property p_timer_en;
        @(posedge sys_clk) disable iff (!reset_n)
        hit(req, mcr_pkg::OFF_MISC) |-> ##2 gp_timer_enable == $past(req.wdata[2], 2);
    endproperty
    a_timer_en: assert property (p_timer_en) else $error("timer enable wrong"); // see RQ1

    property p_gpt_lo;
        @(posedge sys_clk) disable iff (!reset_n)
        hit(req, mcr_pkg::OFF_GPT_LO) |=> gpt_q[7:0] == $past(req.wdata[7:0]);
    endproperty
    a_gpt_lo: assert property (p_gpt_lo) else $error("timer low byte wrong"); // see RQ5

    property p_data_rd;
        @(posedge sys_clk) disable iff (!reset_n)
        req.rd && req.addr == mcr_pkg::OFF_DATA |=> rdata == $past(data_q);
    endproperty
    a_data_rd: assert property (p_data_rd) else $error("data port read wrong"); // see RQ6

    property p_gap1;
        @(posedge sys_clk) disable iff (!reset_n)
        hit(req, mcr_pkg::OFF_GAP1) |-> ##2 frame_gap_segment_one == $past(req.wdata[6:0], 2);
    endproperty
    a_gap1: assert property (p_gap1) else $error("gap one wrong"); // see RQ7

    property p_eeclk;
        @(posedge sys_clk) disable iff (!reset_n)
        hit(req, mcr_pkg::OFF_MGMT) |-> ##2 eeprom_clock == $past(req.wdata[7], 2);
    endproperty
    a_eeclk: assert property (p_eeclk) else $error("eeprom clock wrong"); // see RQ9

    property p_dir;
        @(posedge sys_clk) disable iff (!reset_n)
        hit(req, mcr_pkg::OFF_MGMT) |-> ##2 (phy_mdio_oe == !$past(req.wdata[1], 2))
            && (eeprom_data_oe == phy_mdio_oe);
    endproperty
    a_dir: assert property (p_dir) else $error("direction wrong"); // see RQ15

    property p_irq_od;
        @(posedge sys_clk) disable iff (!reset_n)
        !btype_q[mcr_pkg::BT_IRQ_PUSH] |=> irq_o == 1'b0;
    endproperty
    a_irq_od: assert property (p_irq_od) else $error("open-drain irq drives high"); // see RQ17

    property p_irq_level;
        @(posedge sys_clk) disable iff (!reset_n)
        btype_q[mcr_pkg::BT_IRQ_PUSH] |=> irq_oe
            && (irq_o == ($past(irq_event) ~^ $past(btype_q[mcr_pkg::BT_IRQ_HIGH])));
    endproperty
    a_irq_level: assert property (p_irq_level) else $error("irq level wrong"); // see RQ18

    property p_ring_wrap;
        @(posedge sys_clk) disable iff (!reset_n)
        misc_q[mcr_pkg::MISC_TX_RING] && dma_wr_step
            && (dma_wr_page + 8'h01 == receive_ring_start_page)
            |=> dma_next_page == mcr_pkg::TX_RING_FIRST_PAGE;
    endproperty
    a_ring_wrap: assert property (p_ring_wrap) else $error("ring did not wrap"); // see RQ4

    sequence s_pulse_start;
        wst_q == W_IDLE && wake_rise && btype_q[mcr_pkg::BT_WAKE_PULSE];
    endsequence
    property p_pulse;
        @(posedge sys_clk) disable iff (!reset_n)
        s_pulse_start |=> wst_q == W_PULSE && wcnt_q == 24'(WAKE_CYC - 1);
    endproperty
    a_pulse: assert property (p_pulse) else $error("wake pulse start wrong"); // see RQ19
endmodule : mcr_bank
`default_nettype wire

// ==== rtl/mcr_pkg.sv ====
// Package for the miscellaneous configuration register bank.
// Assumes a single 25 MHz clock and a byte-wide register port with 16-bit data port.
package mcr_pkg;
    // ==========================================================
    // Register offsets
    localparam logic [4:0] OFF_MISC = 5'h0d;
    localparam logic [4:0] OFF_GPT_LO = 5'h0e;
    localparam logic [4:0] OFF_GPT_HI = 5'h0f;
    localparam logic [4:0] OFF_DATA = 5'h10;
    localparam logic [4:0] OFF_GAP1 = 5'h12;
    localparam logic [4:0] OFF_GAP2 = 5'h13;
    localparam logic [4:0] OFF_MGMT = 5'h14;
    localparam logic [4:0] OFF_BTYPE = 5'h15;
    // ==========================================================
    // Reset values
    localparam logic [7:0] RST_MISC = 8'h00;
    localparam logic [7:0] RST_GPT = 8'hff;
    localparam logic [15:0] RST_DATA = 16'h0000;
    localparam logic [6:0] RST_GAP1 = 7'h0c;
    localparam logic [6:0] RST_GAP2 = 7'h12;
    localparam logic [7:0] RST_MGMT = 8'h00;
    localparam logic [7:0] RST_BTYPE = 8'h00;
    // ==========================================================
    // Field positions
    localparam int MISC_TIMER_EN = 2;
    localparam int MISC_BURST_SEL = 1;
    localparam int MISC_TX_RING = 0;
    localparam int MG_EE_CLK = 7;
    localparam int MG_EE_READ = 6;
    localparam int MG_EE_WRITE = 5;
    localparam int MG_EE_SEL = 4;
    localparam int MG_PHY_OUT = 3;
    localparam int MG_PHY_IN = 2;
    localparam int MG_DIR = 1;
    localparam int MG_MDC = 0;
    localparam int BT_WAKE_IRQ_EN = 6;
    localparam int BT_IRQ_PUSH = 5;
    localparam int BT_IRQ_HIGH = 4;
    localparam int BT_WAKE_PULSE = 2;
    localparam int BT_WAKE_PUSH = 1;
    localparam int BT_WAKE_HIGH = 0;
    localparam logic [7:0] BT_WMASK = 8'h77;
    // ==========================================================
    // Transmit ring and timing
    localparam logic [7:0] TX_RING_FIRST_PAGE = 8'h40;
    localparam int CLK_HZ = 25000000;
    localparam int WAKE_PULSE_MS = 60;
    localparam int WAKE_PULSE_CYC = (CLK_HZ / 1000) * WAKE_PULSE_MS;
    // ==========================================================
    // Register port request
    typedef struct packed {
        logic [4:0] addr;
        logic [15:0] wdata;
        logic wr;
        logic rd;
    } mcr_req_t;
endpackage : mcr_pkg

// ==== sim/mcr_pin_model.sv ====
// Model of the serial EEPROM data line and the PHY management data line.
// Assumes the bank's output enables are high while the bank drives the line.
`timescale 1ns/1ps
`default_nettype none
module mcr_pin_model (
    input wire logic eeprom_data_o,
    input wire logic eeprom_data_oe,
    input wire logic phy_mdio_o,
    input wire logic phy_mdio_oe,
    input wire logic ee_drive,
    input wire logic phy_drive,
    output logic eeprom_data_i,
    output logic phy_mdio_i
);
    // ==========================================================
    // Wire resolution
    // The far device drives a line only while the bank has released it.
    assign eeprom_data_i = eeprom_data_oe ? eeprom_data_o : ee_drive;
    assign phy_mdio_i = phy_mdio_oe ? phy_mdio_o : phy_drive;
endmodule : mcr_pin_model
`default_nettype wire

// ==== sim/test_misc_config_register_bank.sv ====
// Self-checking bench for the configuration register bank.
// Assumes the bank and its package are compiled first.
`timescale 1ns/1ps
`default_nettype none
module test_misc_config_register_bank;
    // ==========================================================
    // Signals
    localparam logic [2:0] MV [4] = '{3'h1, 3'h3, 3'h2, 3'h0};
    localparam logic [7:0] PG [4] = '{8'h4f, 8'h4e, 8'h4f, 8'hff};
    localparam logic [7:0] NP [4] = '{8'h40, 8'h4f, 8'h50, 8'h00};
    logic sys_clk = 1'b0;
    logic reset_n = 1'b0;
    mcr_pkg::mcr_req_t req = '0;
    logic irq_event = 1'b0, wake_event = 1'b0, dma_wr_step = 1'b0;
    logic [7:0] dma_wr_page = 8'h00, rx_start = 8'h50;
    logic [1:0] host_addr = 2'h0;
    logic ee_drive = 1'b0, phy_drive = 1'b0, rd_pend = 1'b0;
    logic [15:0] rdata, gp_timer_reload, data_port_out;
    logic [7:0] dma_next_page;
    logic [6:0] gap1, gap2;
    logic burst_addr_bit, gp_timer_enable, data_port_wr, eeprom_clock, eeprom_select;
    logic eeprom_data_o, eeprom_data_oe, eeprom_data_i, phy_mdc, phy_mdio_o, phy_mdio_oe;
    logic phy_mdio_i, irq_o, irq_oe, wake_o, wake_oe, wake_irq;
    logic [15:0] exp_q [$];
    int errors = 0;
    int checks = 0;
    int pulses = 0;

    always #20 sys_clk = ~sys_clk;

    mcr_bank #(.WAKE_CYC(20)) mcr_bank_i (.sys_clk(sys_clk), .reset_n(reset_n), .req(req),
        .rdata(rdata), .irq_event(irq_event), .wake_event(wake_event),
        .dma_wr_page(dma_wr_page), .dma_wr_step(dma_wr_step),
        .receive_ring_start_page(rx_start), .host_addr(host_addr),
        .dma_next_page(dma_next_page), .burst_addr_bit(burst_addr_bit),
        .gp_timer_enable(gp_timer_enable), .gp_timer_reload(gp_timer_reload),
        .data_port_out(data_port_out), .data_port_wr(data_port_wr),
        .frame_gap_segment_one(gap1), .frame_gap_segment_two(gap2),
        .eeprom_clock(eeprom_clock), .eeprom_select(eeprom_select),
        .eeprom_data_o(eeprom_data_o), .eeprom_data_oe(eeprom_data_oe),
        .eeprom_data_i(eeprom_data_i), .phy_mdc(phy_mdc), .phy_mdio_o(phy_mdio_o),
        .phy_mdio_oe(phy_mdio_oe), .phy_mdio_i(phy_mdio_i), .irq_o(irq_o), .irq_oe(irq_oe),
        .wake_o(wake_o), .wake_oe(wake_oe), .wake_irq(wake_irq));

    mcr_pin_model mcr_pin_model_i (.eeprom_data_o(eeprom_data_o),
        .eeprom_data_oe(eeprom_data_oe), .phy_mdio_o(phy_mdio_o), .phy_mdio_oe(phy_mdio_oe),
        .ee_drive(ee_drive), .phy_drive(phy_drive), .eeprom_data_i(eeprom_data_i),
        .phy_mdio_i(phy_mdio_i));

    // ==========================================================
    // Tasks
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp) begin
            errors++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk

    task automatic bus(input logic w, input logic [4:0] a, input logic [15:0] d);
        @(posedge sys_clk);
        req <= '{addr: a, wdata: d, wr: w, rd: !w};
        @(posedge sys_clk);
        req <= '0;
    endtask : bus

    task automatic rd_exp(input logic [4:0] a, input logic [15:0] e);
        exp_q.push_back(e);
        bus(1'b0, a, 16'h0000);
    endtask : rd_exp

    task automatic settle(input int n);
        repeat (n) @(posedge sys_clk);
        @(negedge sys_clk);
    endtask : settle

    task automatic test_done();
        $display("checks=%0d errors=%0d", checks, errors);
        if (errors == 0 && checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : test_done

    // ==========================================================
    // Monitor
    always @(negedge sys_clk) begin
        if (rd_pend) begin
            chk(rdata, exp_q.pop_front());
        end
        rd_pend = req.rd;
        if (data_port_wr === 1'b1) begin
            pulses++;
        end
    end

    initial begin
        #(40 * 5000);
        errors++;
        test_done();
    end

    // ==========================================================
    // Sequence
    initial begin
        logic [15:0] v;
        logic ev;
        logic push;
        logic hi;
        void'($urandom(32'h7a73));
        repeat (3) @(posedge sys_clk);
        reset_n <= 1'b1;
        // Reset values and an unmapped hole.
        rd_exp(mcr_pkg::OFF_MISC, 16'h0000);
        rd_exp(mcr_pkg::OFF_GPT_LO, 16'h00ff);
        rd_exp(mcr_pkg::OFF_GPT_HI, 16'h00ff);
        rd_exp(mcr_pkg::OFF_DATA, 16'h0000);
        rd_exp(mcr_pkg::OFF_GAP1, 16'h000c);
        rd_exp(mcr_pkg::OFF_GAP2, 16'h0012);
        rd_exp(mcr_pkg::OFF_MGMT, 16'h0000);
        rd_exp(mcr_pkg::OFF_BTYPE, 16'h0000);
        rd_exp(5'h11, 16'h0000);
        // Random write and read back, back to back.
        v = 16'($urandom());
        pulses = 0;
        bus(1'b1, mcr_pkg::OFF_GPT_LO, {8'h00, v[7:0]});
        bus(1'b1, mcr_pkg::OFF_GPT_HI, {8'h00, v[15:8]});
        bus(1'b1, mcr_pkg::OFF_DATA, v ^ 16'ha5c3);
        bus(1'b1, mcr_pkg::OFF_GAP1, {8'h00, 1'b1, v[6:0]});
        bus(1'b1, mcr_pkg::OFF_GAP2, {8'h00, 1'b1, v[14:8]});
        bus(1'b1, mcr_pkg::OFF_BTYPE, 16'h00ff);
        rd_exp(mcr_pkg::OFF_GPT_HI, {8'h00, v[15:8]});
        rd_exp(mcr_pkg::OFF_DATA, v ^ 16'ha5c3);
        rd_exp(mcr_pkg::OFF_GAP1, {9'h000, v[6:0]});
        rd_exp(mcr_pkg::OFF_GAP2, {9'h000, v[14:8]});
        rd_exp(mcr_pkg::OFF_BTYPE, 16'h0077);
        settle(3);
        chk(gp_timer_reload, v);
        chk(data_port_out, v ^ 16'ha5c3);
        chk(16'(pulses), 16'h0001);
        chk({2'h0, gap1, gap2}, {2'h0, v[6:0], v[14:8]});
        // Ring wrap, burst selection and timer enable.
        for (int i = 0; i < 4; i++) begin
            bus(1'b1, mcr_pkg::OFF_MISC, {13'h0000, MV[i] | 3'h4});
            @(posedge sys_clk);
            host_addr <= 2'($urandom());
            dma_wr_page <= PG[i];
            dma_wr_step <= 1'b1;
            settle(3);
            chk({8'h00, dma_next_page}, {8'h00, NP[i]});
            chk({15'h0000, burst_addr_bit}, {15'h0000, host_addr[MV[i][1]]});
            chk({15'h0000, gp_timer_enable}, 16'h0001);
        end
        // Bit-banged serial lines, driven then released.
        bus(1'b1, mcr_pkg::OFF_MGMT, 16'h00b9);
        settle(3);
        chk({9'h000, eeprom_clock, eeprom_select, eeprom_data_o, eeprom_data_oe, phy_mdc,
            phy_mdio_o, phy_mdio_oe}, 16'h007f);
        rd_exp(mcr_pkg::OFF_MGMT, 16'h00fd);
        @(posedge sys_clk);
        ee_drive <= 1'b0;
        phy_drive <= 1'b1;
        bus(1'b1, mcr_pkg::OFF_MGMT, 16'h0002);
        settle(4);
        chk({9'h000, eeprom_clock, eeprom_select, eeprom_data_o, eeprom_data_oe, phy_mdc,
            phy_mdio_o, phy_mdio_oe}, 16'h0000);
        rd_exp(mcr_pkg::OFF_MGMT, 16'h0006);
        @(posedge sys_clk);
        ee_drive <= 1'b1;
        phy_drive <= 1'b0;
        settle(4);
        rd_exp(mcr_pkg::OFF_MGMT, 16'h0042);
        // Interrupt and wake pin type, level and enable in every combination.
        for (int i = 0; i < 16; i++) begin
            ev = i[2];
            push = i[1];
            hi = i[0];
            @(posedge sys_clk);
            irq_event <= ev;
            wake_event <= ev;
            bus(1'b1, mcr_pkg::OFF_BTYPE, {9'h000, i[3], push, hi, 2'h0, push, hi});
            settle(3);
            chk({14'h0000, irq_oe, irq_o}, {14'h0000, push | ev, push & (hi ~^ ev)});
            chk({14'h0000, wake_oe, wake_o}, {14'h0000, push | ev, push & (hi ~^ ev)});
            chk({15'h0000, wake_irq}, {15'h0000, i[3] & ev});
        end
        // Wake pulse of a fixed length per event.
        @(posedge sys_clk);
        wake_event <= 1'b0;
        bus(1'b1, mcr_pkg::OFF_BTYPE, 16'h0006);
        settle(3);
        chk({14'h0000, wake_oe, wake_o}, 16'h0003);
        @(posedge sys_clk);
        wake_event <= 1'b1;
        settle(5);
        chk({14'h0000, wake_oe, wake_o}, 16'h0002);
        settle(16);
        chk({14'h0000, wake_oe, wake_o}, 16'h0002);
        settle(1);
        chk({14'h0000, wake_oe, wake_o}, 16'h0003);
        settle(3);
        chk({14'h0000, wake_oe, wake_o}, 16'h0003);
        test_done();
    end
endmodule : test_misc_config_register_bank
`default_nettype wire
